/* File: rtl/mux16_device.sv */
// Purpose: device end of the 16-bit byte-select multiplexed host port
// Assumes: strap and package pins are static levels; host keeps its rules
// Notes: read data comes from a word array indexed by the latched address
`timescale 1ns/1ps
module mux16_device #(
  parameter int depth = 16384
) (
  input wire logic clk,
  input wire logic resetn,
  mux16_if.device bus,
  input wire logic large_package,
  input wire logic port_mode_strap_1,
  input wire logic port_mode_strap_2,
  input wire logic port_mode_strap_3,
  output logic mode_active,
  output logic [13:0] latched_address,
  output logic write_pulse,
  output logic [1:0] write_lanes,
  output logic [15:0] write_data,
  output logic read_pulse
);
  // synchronised pin copies
  logic [3:0] s_pins;
  logic [15:0] s_ad;
  logic s_cs;
  logic s_al;
  logic s_rw;
  logic s_b0;
  logic s_b1;
  logic [3:0] strap_sync;
  // edge history and decoded events
  logic al_prev;
  logic strobe_prev;
  logic any_strobe;
  logic strobe_rise;
  logic latch_fall;
  logic selected;
  logic reading;
  logic write_edge;
  // read access timer and storage
  logic [5:0] access_count;
  logic [15:0] mem [depth];
  logic [15:0] merged;

  // replace the strobed byte lanes of a stored word
  function automatic logic [15:0] merge_lanes(
    input logic [15:0] old_word,
    input logic [15:0] new_word,
    input logic [1:0] lanes
  );
    logic [15:0] result;
    result = old_word;
    if (lanes[0]) result[7:0] = new_word[7:0];
    if (lanes[1]) result[15:8] = new_word[15:8];
    return result;
  endfunction

  // access time elapsed once the timer reaches its ceiling
  function automatic logic access_done(input logic [5:0] count);
    return count >= 6'(mux16_pkg::access_cycles);
  endfunction

  // control pins through two flops
  pin_sync #(
    .width(4)
  ) ctl_sync (
    .clk(clk),
    .resetn(resetn),
    .pin({bus.address_latch_strobe, bus.read_not_write, bus.low_byte_strobe,
      bus.high_byte_strobe}),
    .sync(s_pins)
  );
  pin_sync #(
    .width(1)
  ) cs_sync (
    .clk(clk),
    .resetn(resetn),
    .pin(bus.chip_select),
    .sync(s_cs)
  );
  pin_sync #(
    .width(16)
  ) ad_sync (
    .clk(clk),
    .resetn(resetn),
    .pin(bus.ad),
    .sync(s_ad)
  );
  pin_sync #(
    .width(4)
  ) strap_s (
    .clk(clk),
    .resetn(resetn),
    .pin({large_package, port_mode_strap_1, port_mode_strap_2, port_mode_strap_3}),
    .sync(strap_sync)
  );

  // unpack synchronised control pins
  assign {s_al, s_rw, s_b0, s_b1} = s_pins;
  // decoded strobe events
  assign any_strobe = s_b0 | s_b1;
  assign strobe_rise = any_strobe & ~strobe_prev;
  assign latch_fall = al_prev & ~s_al;
  // port in mode and chip selected
  assign selected = mode_active & s_cs;
  assign reading = selected & s_rw & any_strobe;
  assign write_edge = selected & ~s_rw & strobe_rise;

  // straps sampled continuously after reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_active <= 1'h0;
    end else begin
      mode_active <= &strap_sync;
    end
  end

  // latch strobe history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      al_prev <= 1'h0;
    end else begin
      al_prev <= s_al;
    end
  end

  // byte strobe history, idle low like the pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strobe_prev <= 1'h0;
    end else begin
      strobe_prev <= any_strobe;
    end
  end

  // address latch on falling latch strobe, held until next
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latched_address <= '0;
    end else if (selected && latch_fall) begin
      latched_address <= s_ad[13:0];
    end
  end

  // access timer from strobe rise, restarts on each restrobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      access_count <= '0;
    end else if (!reading) begin
      access_count <= '0;
    end else if (strobe_rise) begin
      access_count <= 6'h01;
    end else if (!access_done(access_count)) begin
      access_count <= access_count + 6'h01;
    end
  end

  // pins driven only while selected, reading and strobing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus.dev_ad_oe <= 1'h0;
    end else begin
      bus.dev_ad_oe <= reading;
    end
  end

  // junk until the access time elapses, then the full word
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus.dev_ad_out <= mux16_pkg::zero_word;
    end else if (access_done(access_count)) begin
      bus.dev_ad_out <= mem[latched_address];
    end else begin
      bus.dev_ad_out <= mux16_pkg::junk_word;
    end
  end

  // byte lane merge for writes
  always_comb begin
    merged = merge_lanes(mem[latched_address], s_ad, {s_b1, s_b0});
  end

  // write on strobe rise; data was set up before the strobe
  always_ff @(posedge clk) begin
    if (write_edge) begin
      mem[latched_address] <= merged;
    end
  end

  // one pulse per write strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      write_pulse <= 1'h0;
    end else begin
      write_pulse <= write_edge;
    end
  end

  // lanes and data seen with each strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      write_lanes <= 2'h0;
      write_data <= mux16_pkg::zero_word;
    end else begin
      write_lanes <= {s_b1, s_b0};
      write_data <= s_ad;
    end
  end

  // one pulse per read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      read_pulse <= 1'h0;
    end else begin
      read_pulse <= reading && strobe_rise;
    end
  end
endmodule

/* File: shared/mux16_pkg.sv */
// Purpose: shared constants for the 16-bit multiplexed byte-select host port
// Assumes: one 250 MHz clock on both ends; pins cross into it through two flops
// Notes: timing counts are in clk cycles derived from ns figures
// Contract
// - enter mode only on large package, straps high
// - sixteen shared pins; low fourteen carry address
// - direction high reads, low writes
// - host never latches while strobing bytes
// - pins released unless selected, reading, strobing
// - host read: select, latch, direction, strobe
// - read drives junk, then data, release
// - reads always drive full sixteen bits
// - writes use byte lanes per strobe
// - restrobe reuses latched address
// - host chip select optional, else high
// - byte strobes may be tied together
package mux16_pkg;
  localparam int data_w = 16;
  localparam int addr_w = 14;
  localparam int byte_w = 8;
  localparam int clk_period_ns = 4;
  localparam int access_time_ns = 40;
  localparam int access_cycles = (access_time_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int host_phase_ns = 24;
  localparam int host_phase_cycles = (host_phase_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [data_w-1:0] junk_word = 16'hA5A5;
  localparam logic [data_w-1:0] zero_word = 16'h0000;
endpackage

/* File: shared/mux16_if.sv */
// Purpose: shared pin bundle between host and device ends
// Assumes: each end drives ad only while its enable is high
// Notes: resolved ad is the driving end's value, else all ones pull-up
`timescale 1ns/1ps
interface mux16_if;
  logic chip_select;
  logic address_latch_strobe;
  logic read_not_write;
  logic low_byte_strobe;
  logic high_byte_strobe;
  logic [15:0] host_ad_out;
  logic host_ad_oe;
  logic [15:0] dev_ad_out;
  logic dev_ad_oe;
  logic [15:0] ad;
  // wired bus resolution
  assign ad = host_ad_oe ? host_ad_out : (dev_ad_oe ? dev_ad_out : 16'hFFFF);
  modport host (output chip_select, output address_latch_strobe, output read_not_write,
    output low_byte_strobe, output high_byte_strobe, output host_ad_out, output host_ad_oe,
    input ad);
  modport device (input chip_select, input address_latch_strobe, input read_not_write,
    input low_byte_strobe, input high_byte_strobe, output dev_ad_out, output dev_ad_oe,
    input ad);
endinterface

/* File: rtl/pin_sync.sv */
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module pin_sync #(
  parameter int width = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [width-1:0] pin,
  output logic [width-1:0] sync
);
  logic [width-1:0] meta;
  // two stages
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= pin;
      sync <= meta;
    end
  end
endmodule

/* File: rtl/mux16_host.sv */
// Purpose: host end issuing latch, read and write cycles on the shared pins
// Assumes: one request taken when idle; phases last host_phase_cycles + 1 cycles, strobe phase adds access_cycles
// Notes: restrobe skips the latch phase
`timescale 1ns/1ps
module mux16_host (
  input wire logic clk,
  input wire logic resetn,
  mux16_if.host bus,
  input wire logic use_chip_select,
  input wire logic req,
  input wire logic req_write,
  input wire logic req_same_address,
  input wire logic [1:0] req_lanes,
  input wire logic [13:0] req_address,
  input wire logic [15:0] req_data,
  output logic busy,
  output logic done,
  output logic [15:0] rdata
);
  typedef enum {idle, addr_setup, latch_high, latch_low, turn, strobe, release_p} host_state_t;
  host_state_t state;
  logic [4:0] phase;
  logic wr;
  logic [1:0] lanes;
  logic [15:0] wdata;
  logic [15:0] s_ad;
  logic phase_done;

  pin_sync #(.width(16)) rd_sync (.clk(clk), .resetn(resetn), .pin(bus.ad), .sync(s_ad));
  assign phase_done = (phase == 5'(mux16_pkg::host_phase_cycles + mux16_pkg::access_cycles));

  // sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= idle;
      phase <= '0;
      wr <= 1'b0;
      lanes <= 2'b00;
      wdata <= mux16_pkg::zero_word;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= mux16_pkg::zero_word;
      bus.chip_select <= 1'b0;
      bus.address_latch_strobe <= 1'b0;
      bus.read_not_write <= 1'b0;
      bus.low_byte_strobe <= 1'b0;
      bus.high_byte_strobe <= 1'b0;
      bus.host_ad_out <= mux16_pkg::zero_word;
      bus.host_ad_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      phase <= phase + 5'd1;
      bus.chip_select <= use_chip_select ? busy : 1'b1;
      case (state)
        idle: begin
          phase <= '0;
          if (req) begin
            busy <= 1'b1;
            wr <= req_write;
            lanes <= (req_lanes == 2'b00) ? 2'b11 : req_lanes;
            wdata <= req_data;
            if (req_same_address) state <= turn;
            else begin
              bus.host_ad_out <= {2'b00, req_address};
              bus.host_ad_oe <= 1'b1;
              state <= addr_setup;
            end
          end
        end
        addr_setup: if (phase == 5'(mux16_pkg::host_phase_cycles)) begin
          bus.address_latch_strobe <= 1'b1;
          phase <= '0;
          state <= latch_high;
        end
        latch_high: if (phase == 5'(mux16_pkg::host_phase_cycles)) begin
          bus.address_latch_strobe <= 1'b0;
          phase <= '0;
          state <= latch_low;
        end
        latch_low: if (phase == 5'(mux16_pkg::host_phase_cycles)) begin
          phase <= '0;
          state <= turn;
        end
        turn: begin
          bus.read_not_write <= !wr;
          bus.host_ad_oe <= wr;
          bus.host_ad_out <= wdata;
          if (phase == 5'(mux16_pkg::host_phase_cycles)) begin
            bus.low_byte_strobe <= lanes[0];
            bus.high_byte_strobe <= lanes[1];
            phase <= '0;
            state <= strobe;
          end
        end
        strobe: if (phase_done) begin
          if (!wr) rdata <= s_ad;
          bus.low_byte_strobe <= 1'b0;
          bus.high_byte_strobe <= 1'b0;
          phase <= '0;
          state <= release_p;
        end
        release_p: if (phase == 5'(mux16_pkg::host_phase_cycles)) begin
          bus.host_ad_oe <= 1'b0;
          busy <= 1'b0;
          done <= 1'b1;
          state <= idle;
        end
        default: state <= idle;
      endcase
    end
  end
endmodule

/* File: sim/mux16_chk.sv */
// Purpose: pin-level checks on the shared port between host and device
// Assumes: straps held high while strobes move; signals watched at clk
// Notes: watches the interface only, no bind
`timescale 1ns/1ps
module mux16_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic chip_select,
  input wire logic address_latch_strobe,
  input wire logic read_not_write,
  input wire logic low_byte_strobe,
  input wire logic high_byte_strobe,
  input wire logic host_ad_oe,
  input wire logic dev_ad_oe,
  input wire logic [15:0] ad
);
  logic strobe;
  // either byte strobe
  assign strobe = low_byte_strobe | high_byte_strobe;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_read_start;
    chip_select && read_not_write && $rose(strobe);
  endsequence
  sequence s_junk_phase;
    (ad == mux16_pkg::junk_word) [*8];
  endsequence
  sequence s_idle_pins;
    !(chip_select && read_not_write && strobe) [*5];
  endsequence
  a_read_drives: assert property (s_read_start |-> ##[1:8] dev_ad_oe)
    else $error("read strobe not answered");
  a_junk_first: assert property ($rose(dev_ad_oe) |-> s_junk_phase)
    else $error("read data too early");
  a_release_idle: assert property (s_idle_pins |-> !dev_ad_oe)
    else $error("device drives while idle");
  a_latch_apart: assert property (chip_select |-> !(address_latch_strobe && strobe))
    else $error("latch overlaps byte strobe");
  a_host_listens: assert property (read_not_write && strobe |-> !host_ad_oe)
    else $error("host drives during read");
  a_write_driven: assert property (!read_not_write && strobe |-> host_ad_oe)
    else $error("write strobe without data");
  a_latch_addr: assert property ($fell(address_latch_strobe) |-> $past(host_ad_oe))
    else $error("latch without address");
  a_dir_steady: assert property (strobe && $past(strobe) |-> $stable(read_not_write))
    else $error("direction moved in strobe");
  a_no_fight: assert property (!(host_ad_oe && dev_ad_oe))
    else $error("both ends drive bus");
endmodule

/* File: sim/tb.sv */
// Purpose: random and corner traffic between host and device ends
// Assumes: one clock; straps swept first, then left high
// Notes: every read address is written whole before it is read
`timescale 1ns/1ps
module tb;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [3:0] straps;
  logic use_cs, req, req_write, req_same, mode_active, write_pulse, read_pulse, done, busy;
  logic [1:0] req_lanes, write_lanes, exp_lanes, ln;
  logic [13:0] req_address, latched_address, exp_addr, a;
  logic [15:0] req_data, write_data, rdata, exp_data, d, d2, want;
  integer seed = 32'h92381868;
  int fails = 0, samples_checked = 0, cyc = 0;
  int wr_seen = 0, rd_seen = 0;
  mux16_if bus_if();
  mux16_device i_mux16_device (.clk(clk), .resetn(resetn), .bus(bus_if),
    .large_package(straps[3]), .port_mode_strap_1(straps[2]),
    .port_mode_strap_2(straps[1]), .port_mode_strap_3(straps[0]),
    .mode_active(mode_active), .latched_address(latched_address),
    .write_pulse(write_pulse), .write_lanes(write_lanes), .write_data(write_data),
    .read_pulse(read_pulse));
  mux16_host i_mux16_host (.clk(clk), .resetn(resetn), .bus(bus_if), .use_chip_select(use_cs),
    .req(req), .req_write(req_write), .req_same_address(req_same), .req_lanes(req_lanes),
    .req_address(req_address), .req_data(req_data), .busy(busy), .done(done), .rdata(rdata));
  mux16_chk chk (.clk(clk), .resetn(resetn), .chip_select(bus_if.chip_select),
    .address_latch_strobe(bus_if.address_latch_strobe),
    .read_not_write(bus_if.read_not_write), .low_byte_strobe(bus_if.low_byte_strobe),
    .high_byte_strobe(bus_if.high_byte_strobe), .host_ad_oe(bus_if.host_ad_oe),
    .dev_ad_oe(bus_if.dev_ad_oe), .ad(bus_if.ad));
  // clock and hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      results();
    end
  end
  function automatic logic [15:0] lane_mask(input logic [1:0] l);
    return {{8{l[1]}}, {8{l[0]}}};
  endfunction
  // stored word after a lane write over an older word
  function automatic logic [15:0] expect_word(input logic [15:0] old_v,
    input logic [15:0] new_v, input logic [1:0] l);
    return (old_v & ~lane_mask(l)) | (new_v & lane_mask(l));
  endfunction
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp_v);
    samples_checked++;
    if (got !== exp_v) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp_v);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp_v);
    samples_checked++;
    if (got !== exp_v) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp_v);
    end
  endtask
  task automatic results();
    $display("checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one host transfer, waits for done
  task automatic op(input logic w, input logic s, input logic [1:0] l, input logic [15:0] v);
    int k;
    k = 0;
    if (!s) exp_addr = a;
    exp_lanes = l;
    exp_data = v;
    @(negedge clk);
    {req, req_write, req_same, req_lanes, req_address, req_data} = {1'h1, w, s, l, a, v};
    @(negedge clk);
    req = 1'h0;
    cmp_flag(busy, 1'h1);
    while (done !== 1'h1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    cmp_flag(done, 1'h1);
    cmp_flag(busy, 1'h0);
  endtask
  // device side effects of each strobe, looked at mid-cycle
  always @(negedge clk) begin
    if (write_pulse === 1'h1) begin
      wr_seen++;
      cmp_word({2'h0, latched_address}, {2'h0, exp_addr});
      cmp_word({14'h0, write_lanes}, {14'h0, exp_lanes});
      cmp_word(write_data & lane_mask(exp_lanes), exp_data & lane_mask(exp_lanes));
    end
    if (read_pulse === 1'h1) begin
      rd_seen++;
      cmp_word({2'h0, latched_address}, {2'h0, exp_addr});
    end
  end
  initial begin
    {straps, use_cs, req, req_write, req_same, req_lanes} = 10'h3E0;
    {req_address, req_data} = 30'h0;
    repeat (5) @(posedge clk);
    @(negedge clk) resetn = 1'h1;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk) straps = i[3:0];
      repeat (6) @(negedge clk);
      cmp_flag(mode_active, i == 15);
    end
    $display("test mode_straps done");
    for (int n = 0; n < 14; n++) begin
      a = (n == 0) ? 14'h0000 : (n == 1) ? 14'h3FFF : 14'($random(seed));
      d = 16'($random(seed));
      d2 = 16'($random(seed));
      ln = ($random(seed) & 1) ? 2'h1 : 2'h2;
      use_cs = 1'($random(seed));
      op(1'h1, 1'h0, 2'h3, d);
      op(1'h1, 1'h1, ln, d2);
      want = expect_word(d, d2, ln);
      op(1'h0, 1'h0, 2'(n % 4), 16'h0000);
      cmp_word(rdata, want);
      op(1'h0, 1'h1, ln, 16'h0000);
      cmp_word(rdata, want);
    end
    cmp_word(16'(wr_seen), 16'h001C);
    cmp_word(16'(rd_seen), 16'h001C);
    $display("test traffic done");
    results();
  end
endmodule
